/* sdio_pkg.sv */
// Shared constants for the servo drive status and command-select logic
package sdio_pkg;

	// =====================================================================
	// Widths
	// =====================================================================
	localparam int SPD_W = 16; // Speed values, signed r/min
	localparam int POS_W = 24; // Position deviation, signed pulses
	localparam int OUT_N = 11; // Number of mappable status functions
	localparam int PIN_N = 6; // Physical output pins

	// =====================================================================
	// APB register byte offsets
	// =====================================================================
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_ZERO_SPEED_OUT_THR = 8'h04;
	localparam logic [7:0] ADDR_SPEED_REACHED_OUT_THR = 8'h08;
	localparam logic [7:0] ADDR_POS_WIN = 8'h0c;
	localparam logic [7:0] ADDR_SMATCH_WIN = 8'h10;
	localparam logic [7:0] ADDR_PRESET_A = 8'h14;
	localparam logic [7:0] ADDR_PRESET_B = 8'h18;
	localparam logic [7:0] ADDR_PRESET_C = 8'h1c;
	localparam logic [7:0] ADDR_PIN_MAP = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h2c;
	localparam logic [7:0] ADDR_SPD_CMD = 8'h30;

	// =====================================================================
	// Operation modes (low bits of mode register)
	// =====================================================================
	localparam logic [2:0] MODE_PT = 3'h0; // Pulse position mode
	localparam logic [2:0] MODE_S = 3'h1;
	localparam logic [2:0] MODE_T = 3'h2;
	localparam logic [2:0] MODE_SZ = 3'h3; // Zero speed command mode
	localparam logic [2:0] MODE_TZ = 3'h4; // Zero torque command mode
	localparam logic [2:0] MODE_PT_S = 3'h5;
	localparam logic [2:0] MODE_PT_T = 3'h6;
	localparam logic [2:0] MODE_S_T = 3'h7;

	// =====================================================================
	// Status function indices (pin map codes are index + 1, 0 = unmapped)
	// =====================================================================
	localparam int F_READY = 0;
	localparam int F_ENERG = 1;
	localparam int F_ZERO_SPEED_OUT = 2;
	localparam int F_SPEED_REACHED_OUT = 3;
	localparam int F_POSITION_REACHED_OUT = 4;
	localparam int F_TQL = 5;
	localparam int F_FAULT = 6;
	localparam int F_BRAKE = 7;
	localparam int F_OVLD = 8;
	localparam int F_WARN = 9;
	localparam int F_SMATCH = 10;

	// =====================================================================
	// Reset values
	// =====================================================================
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [SPD_W-1:0] ZERO_SPEED_OUT_RST = 16'h000a;
	localparam logic [SPD_W-1:0] SPEED_REACHED_OUT_RST = 16'h0bb8;
	localparam logic [POS_W-1:0] POS_WIN_RST = 24'h000064;
	localparam logic [SPD_W-1:0] SMATCH_RST = 16'h000a;
	localparam logic [SPD_W-1:0] PRESET_A_RST = 16'h0064;
	localparam logic [SPD_W-1:0] PRESET_B_RST = 16'h00c8;
	localparam logic [SPD_W-1:0] PRESET_C_RST = 16'h012c;
	// Pin codes: pin0 ready, pin1 zero speed, pin2 target speed, pin3 position,
	// pin4 fault, pin5 unmapped; each code is a 4-bit nibble
	// The brake contact has no default pin, so it stays off the pins until mapped
	localparam logic [23:0] PIN_MAP_RST = 24'h075431;

endpackage

/* sdio_status.sv */
// Servo drive status outputs, speed command select and APB register file
// =====================================================================
// Notes on behaviour
// - Ready only when powered and free of control and power alarms.
// - Energized when energize input and servo healthy.
// - Zero speed when speed below threshold.
// - Speed reached when speed exceeds threshold.
// - Position reached in position modes when deviation within window.
// - Torque limiting, except torque modes.
// - Fault on alarms except warning classes.
// - Warning on limits, stop, comms, undervoltage.
// - Overload once overload level reached.
// - Speed match in speed modes only.
// - Output drives holding brake contact.
// - Unmapped functions stay off on pins.
// =====================================================================
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module sdio_status (
	// Clock and synchronous active-low reset
	input wire logic clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive state
	// All drive state inputs are active-high levels, synchronous to clk
	input wire logic power_ok,
	input wire logic ctrl_alarm,
	input wire logic power_alarm,
	input wire logic other_alarm,
	input wire logic drive_energized,
	input wire logic servo_ok,
	// Warning classes, then overload, torque limit and brake: these never raise the fault output
	input wire logic limit_fwd,
	input wire logic limit_rev,
	input wire logic emergency_stop,
	input wire logic comm_error,
	input wire logic under_voltage,
	input wire logic overload_level,
	input wire logic torque_limit_active,
	input wire logic brake_release,
	// Speeds are signed r/min
	input wire logic signed [15:0] motor_speed,
	input wire logic signed [15:0] analog_speed,
	// Pulse trains: one count per clock, direction high counts down
	input wire logic cmd_pulse,
	input wire logic cmd_dir,
	input wire logic fb_pulse,
	input wire logic fb_dir,
	// Digital inputs from the host
	input wire logic speed_select_bit0,
	input wire logic speed_select_bit1,
	input wire logic deviation_clear_in,
	// Outputs
	// Selected speed command, registered
	output logic signed [15:0] speed_command,
	// Status functions, registered one clock after their inputs
	output logic drive_ready_out,
	output logic energized_out,
	output logic zero_speed_out,
	output logic speed_reached_out,
	output logic position_reached_out,
	output logic torque_limiting_out,
	output logic fault_out,
	output logic brake_contact_out,
	output logic overload_out,
	output logic warning_out,
	output logic speed_match_out,
	// Physical output pins after function mapping
	output logic [5:0] do_pin,
	// Level interrupt from sticky events and mask
	output logic irq
);

	// =====================================================================
	// State
	// =====================================================================
	// One struct holds every flop, so reset and update each stay in one place
	typedef struct packed {
		logic [2:0] mode; // Operation mode
		logic [15:0] zero_speed_out_thr; // Zero speed threshold
		logic [15:0] speed_reached_out_thr; // Target speed threshold
		logic [23:0] pos_win; // Position window
		logic [15:0] smatch_win; // Speed match window
		logic [15:0] preset_a;
		logic [15:0] preset_b;
		logic [15:0] preset_c;
		logic [23:0] pin_map; // Six 4-bit function codes
		logic [10:0] func; // Registered status functions
		logic [10:0] irq_stat; // Sticky rising-edge events
		logic [10:0] irq_mask;
		logic [23:0] deviation; // Commanded minus actual pulses
		logic [15:0] spd_cmd; // Selected speed command
		logic [5:0] pins;
		logic [31:0] rdata;
	} sdio_state_t;

	// Registered state and its next value
	sdio_state_t st_q;
	sdio_state_t st_d;

	// Combinational helpers
	// Function vector in status bit order
	logic [10:0] func_now;
	// Speed magnitudes carry one extra bit for the most negative input
	logic [16:0] abs_speed;
	logic [16:0] spd_diff;
	logic [16:0] abs_sdiff;
	logic [23:0] abs_dev;
	// Mode class flags
	logic is_pos_mode;
	logic is_zero_speed_mode;
	// Bus strobes and address decode
	logic wr_en;
	logic rd_en;
	logic addr_ok;

	// =====================================================================
	// Status function evaluation
	// =====================================================================
	// Speed magnitudes are formed one bit wider so the most negative value is safe
	always_comb begin
		abs_speed = motor_speed[15] ? 17'(-$signed({motor_speed[15], motor_speed})) : {1'b0, motor_speed};
		spd_diff = 17'($signed({st_q.spd_cmd[15], st_q.spd_cmd}) - $signed({motor_speed[15], motor_speed}));
		abs_sdiff = spd_diff[16] ? 17'(-$signed(spd_diff)) : spd_diff;
		abs_dev = st_q.deviation[23] ? 24'(-$signed(st_q.deviation)) : st_q.deviation;
		is_pos_mode = (st_q.mode == sdio_pkg::MODE_PT) || (st_q.mode == sdio_pkg::MODE_PT_S) ||
			(st_q.mode == sdio_pkg::MODE_PT_T);
		is_zero_speed_mode = (st_q.mode == sdio_pkg::MODE_SZ);
		// Functions are evaluated from live inputs, the current thresholds and mode, the deviation counter and the registered command
		func_now = '0;
		func_now[sdio_pkg::F_READY] = power_ok && !ctrl_alarm && !power_alarm;
		func_now[sdio_pkg::F_ENERG] = drive_energized && servo_ok;
		// Speed compares use magnitude, so reverse rotation behaves like forward
		func_now[sdio_pkg::F_ZERO_SPEED_OUT] = abs_speed < {1'b0, st_q.zero_speed_out_thr};
		func_now[sdio_pkg::F_SPEED_REACHED_OUT] = abs_speed > {1'b0, st_q.speed_reached_out_thr};
		func_now[sdio_pkg::F_POSITION_REACHED_OUT] = is_pos_mode && (abs_dev < st_q.pos_win);
		// Torque modes never report limiting since torque is the command there
		func_now[sdio_pkg::F_TQL] = torque_limit_active && (st_q.mode != sdio_pkg::MODE_T) &&
			(st_q.mode != sdio_pkg::MODE_TZ);
		// Alarm classes are disjoint: limits, stop, comms and undervoltage only warn
		func_now[sdio_pkg::F_FAULT] = ctrl_alarm || power_alarm || other_alarm;
		func_now[sdio_pkg::F_BRAKE] = brake_release;
		func_now[sdio_pkg::F_OVLD] = overload_level;
		func_now[sdio_pkg::F_WARN] = limit_fwd || limit_rev || emergency_stop || comm_error ||
			under_voltage;
		// Match uses the registered command, so it trails a select change by a clock
		func_now[sdio_pkg::F_SMATCH] = ((st_q.mode == sdio_pkg::MODE_S) || is_zero_speed_mode) &&
			(abs_sdiff < {1'b0, st_q.smatch_win});
	end

	// =====================================================================
	// APB decode
	// =====================================================================
	// Zero wait state slave: pready is always high
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	// Any address outside the map is refused with an error in the access phase
	always_comb begin
		case (paddr)
			sdio_pkg::ADDR_MODE, sdio_pkg::ADDR_ZERO_SPEED_OUT_THR, sdio_pkg::ADDR_SPEED_REACHED_OUT_THR,
			sdio_pkg::ADDR_POS_WIN, sdio_pkg::ADDR_SMATCH_WIN, sdio_pkg::ADDR_PRESET_A,
			sdio_pkg::ADDR_PRESET_B, sdio_pkg::ADDR_PRESET_C, sdio_pkg::ADDR_PIN_MAP,
			sdio_pkg::ADDR_STATUS, sdio_pkg::ADDR_IRQ_STAT, sdio_pkg::ADDR_IRQ_MASK,
			sdio_pkg::ADDR_SPD_CMD: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// =====================================================================
	// Next state
	// =====================================================================
	always_comb begin
		st_d = st_q;
		// Status functions are registered as they stand
		st_d.func = func_now;
		// Speed command source select; the select inputs are synchronous levels
		case ({speed_select_bit1, speed_select_bit0})
			2'b00: st_d.spd_cmd = is_zero_speed_mode ? 16'h0000 : analog_speed;
			2'b01: st_d.spd_cmd = st_q.preset_a;
			2'b10: st_d.spd_cmd = st_q.preset_b;
			default: st_d.spd_cmd = st_q.preset_c;
		endcase
		// Deviation counter; clear has priority over counting in pulse mode
		// Commanded pulses add, feedback pulses subtract; the counter wraps at 24 bits
		if (deviation_clear_in && (st_q.mode == sdio_pkg::MODE_PT)) begin
			st_d.deviation = '0;
		end else begin
			st_d.deviation = st_q.deviation + (cmd_pulse ? (cmd_dir ? 24'hffffff : 24'h000001) : 24'h000000)
				- (fb_pulse ? (fb_dir ? 24'hffffff : 24'h000001) : 24'h000000);
		end
		// Pin mapping; code 0 or an unknown code leaves the pin off
		// Codes above eleven count as unmapped, so stray writes cannot light a pin
		for (int i = 0; i < sdio_pkg::PIN_N; i++) begin
			st_d.pins[i] = 1'b0;
			for (int f = 0; f < sdio_pkg::OUT_N; f++) begin
				if (st_q.pin_map[i*4 +: 4] == 4'(f + 1)) begin
					st_d.pins[i] = func_now[f];
				end
			end
		end
		// Read data captured in setup so it is stable in access phase
		if (rd_en) begin
			case (paddr)
				sdio_pkg::ADDR_MODE: st_d.rdata = {29'h0, st_q.mode};
				sdio_pkg::ADDR_ZERO_SPEED_OUT_THR: st_d.rdata = {16'h0, st_q.zero_speed_out_thr};
				sdio_pkg::ADDR_SPEED_REACHED_OUT_THR: st_d.rdata = {16'h0, st_q.speed_reached_out_thr};
				sdio_pkg::ADDR_POS_WIN: st_d.rdata = {8'h0, st_q.pos_win};
				sdio_pkg::ADDR_SMATCH_WIN: st_d.rdata = {16'h0, st_q.smatch_win};
				sdio_pkg::ADDR_PRESET_A: st_d.rdata = {16'h0, st_q.preset_a};
				sdio_pkg::ADDR_PRESET_B: st_d.rdata = {16'h0, st_q.preset_b};
				sdio_pkg::ADDR_PRESET_C: st_d.rdata = {16'h0, st_q.preset_c};
				sdio_pkg::ADDR_PIN_MAP: st_d.rdata = {8'h0, st_q.pin_map};
				sdio_pkg::ADDR_STATUS: st_d.rdata = {21'h0, st_q.func};
				sdio_pkg::ADDR_IRQ_STAT: st_d.rdata = {21'h0, st_q.irq_stat};
				sdio_pkg::ADDR_IRQ_MASK: st_d.rdata = {21'h0, st_q.irq_mask};
				sdio_pkg::ADDR_SPD_CMD: st_d.rdata = {16'h0, st_q.spd_cmd};
				// Unmapped reads return zero
				default: st_d.rdata = 32'h00000000;
			endcase
		end
		// Register writes
		// Status and speed command are read only, so writes there fall to the default
		if (wr_en) begin
			case (paddr)
				sdio_pkg::ADDR_MODE: st_d.mode = pwdata[2:0];
				sdio_pkg::ADDR_ZERO_SPEED_OUT_THR: st_d.zero_speed_out_thr = pwdata[15:0];
				sdio_pkg::ADDR_SPEED_REACHED_OUT_THR: st_d.speed_reached_out_thr = pwdata[15:0];
				sdio_pkg::ADDR_POS_WIN: st_d.pos_win = pwdata[23:0];
				sdio_pkg::ADDR_SMATCH_WIN: st_d.smatch_win = pwdata[15:0];
				sdio_pkg::ADDR_PRESET_A: st_d.preset_a = pwdata[15:0];
				sdio_pkg::ADDR_PRESET_B: st_d.preset_b = pwdata[15:0];
				sdio_pkg::ADDR_PRESET_C: st_d.preset_c = pwdata[15:0];
				sdio_pkg::ADDR_PIN_MAP: st_d.pin_map = pwdata[23:0];
				sdio_pkg::ADDR_IRQ_MASK: st_d.irq_mask = pwdata[10:0];
				default: st_d.mode = st_q.mode;
			endcase
		end
		// Sticky events on rising edges; a new event wins over a write-one clear
		// Clear first, then set, so an event in the clear cycle is never lost
		if (wr_en && (paddr == sdio_pkg::ADDR_IRQ_STAT)) begin
			st_d.irq_stat = st_q.irq_stat & ~pwdata[10:0];
		end
		st_d.irq_stat = st_d.irq_stat | (func_now & ~st_q.func);
	end

	// =====================================================================
	// State register
	// =====================================================================
	// No clock enable: every register updates on every edge
	// Reset is synchronous and loads the package reset values
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.mode <= sdio_pkg::MODE_RST;
			st_q.zero_speed_out_thr <= sdio_pkg::ZERO_SPEED_OUT_RST;
			st_q.speed_reached_out_thr <= sdio_pkg::SPEED_REACHED_OUT_RST;
			st_q.pos_win <= sdio_pkg::POS_WIN_RST;
			st_q.smatch_win <= sdio_pkg::SMATCH_RST;
			st_q.preset_a <= sdio_pkg::PRESET_A_RST;
			st_q.preset_b <= sdio_pkg::PRESET_B_RST;
			st_q.preset_c <= sdio_pkg::PRESET_C_RST;
			st_q.pin_map <= sdio_pkg::PIN_MAP_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// =====================================================================
	// Outputs
	// =====================================================================
	// Bus outputs
	assign prdata = st_q.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok; // Unmapped address answers with an error
	// Command and status outputs come straight from flops
	assign speed_command = st_q.spd_cmd;
	assign drive_ready_out = st_q.func[sdio_pkg::F_READY];
	assign energized_out = st_q.func[sdio_pkg::F_ENERG];
	assign zero_speed_out = st_q.func[sdio_pkg::F_ZERO_SPEED_OUT];
	assign speed_reached_out = st_q.func[sdio_pkg::F_SPEED_REACHED_OUT];
	assign position_reached_out = st_q.func[sdio_pkg::F_POSITION_REACHED_OUT];
	assign torque_limiting_out = st_q.func[sdio_pkg::F_TQL];
	assign fault_out = st_q.func[sdio_pkg::F_FAULT];
	assign brake_contact_out = st_q.func[sdio_pkg::F_BRAKE];
	assign overload_out = st_q.func[sdio_pkg::F_OVLD];
	assign warning_out = st_q.func[sdio_pkg::F_WARN];
	assign speed_match_out = st_q.func[sdio_pkg::F_SMATCH];
	// Pins and interrupt
	assign do_pin = st_q.pins;
	assign irq = |(st_q.irq_stat & st_q.irq_mask);

endmodule

`default_nettype wire

/* sdio_props.sv */
// Port checks for the servo status block
`timescale 1ns/10ps
`default_nettype none
module sdio_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic power_ok,
	input wire logic ctrl_alarm,
	input wire logic power_alarm,
	input wire logic other_alarm,
	input wire logic drive_energized,
	input wire logic servo_ok,
	input wire logic limit_fwd,
	input wire logic limit_rev,
	input wire logic emergency_stop,
	input wire logic comm_error,
	input wire logic under_voltage,
	input wire logic overload_level,
	input wire logic brake_release,
	input wire logic drive_ready_out,
	input wire logic energized_out,
	input wire logic fault_out,
	input wire logic brake_contact_out,
	input wire logic overload_out,
	input wire logic warning_out
);
	// =====================================================================
	// One domain, so one clock and one reset serve every check
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_ready_clean: assert property (1'b1 |=> drive_ready_out == $past(power_ok && !ctrl_alarm && !power_alarm))
		else $error("ready output wrong");
	chk_energ_follow: assert property (1'b1 |=> energized_out == $past(drive_energized && servo_ok))
		else $error("energized output wrong");
	chk_fault_classes: assert property (1'b1 |=> fault_out == $past(ctrl_alarm || power_alarm || other_alarm))
		else $error("fault output wrong");
	chk_warn_classes: assert property (##1 warning_out ==
		$past(limit_fwd || limit_rev || emergency_stop || comm_error || under_voltage))
		else $error("warning output wrong");
	chk_overload_level: assert property ($rose(overload_level) |=> overload_out)
		else $error("overload output late");
	chk_brake_contact: assert property (brake_release != brake_contact_out |=>
		brake_contact_out == $past(brake_release))
		else $error("brake contact wrong");
	// Aligned words above the map must be refused in the access phase
	chk_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h30))
		else $error("slave error wrong");
	// Read data only moves after a read setup cycle
	chk_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
endmodule
bind sdio_status sdio_props sdio_props_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .power_ok(power_ok),
	.ctrl_alarm(ctrl_alarm), .power_alarm(power_alarm), .other_alarm(other_alarm),
	.drive_energized(drive_energized), .servo_ok(servo_ok), .limit_fwd(limit_fwd), .limit_rev(limit_rev),
	.emergency_stop(emergency_stop), .comm_error(comm_error), .under_voltage(under_voltage),
	.overload_level(overload_level), .brake_release(brake_release), .drive_ready_out(drive_ready_out),
	.energized_out(energized_out), .fault_out(fault_out), .brake_contact_out(brake_contact_out),
	.overload_out(overload_out), .warning_out(warning_out));
`default_nettype wire

/* sdio_host.sv */
// Host controller model: speed select, deviation clear and pulse trains
`timescale 1ns/10ps
`default_nettype none
module sdio_host (
	input wire logic clk,
	output logic speed_select_bit0,
	output logic speed_select_bit1,
	output logic deviation_clear_in,
	output logic cmd_pulse,
	output logic cmd_dir,
	output logic fb_pulse,
	output logic fb_dir
);
	// =====================================================================
	// Idle levels before the bench asks for anything
	initial begin
		{speed_select_bit0, speed_select_bit1, deviation_clear_in} = 3'h0;
		{cmd_pulse, cmd_dir, fb_pulse, fb_dir} = 4'h0;
	end
	// Select code and clear level, changed just after an edge
	task automatic sel(input logic [1:0] s, input logic c);
		speed_select_bit0 <= s[0];
		speed_select_bit1 <= s[1];
		deviation_clear_in <= c;
	endtask
	// One count per clock; the direction holds after the train
	task automatic pulses(input int n, input logic fb, input logic dir);
		cmd_dir <= dir;
		fb_dir <= dir;
		repeat (n) begin
			@(posedge clk);
			cmd_pulse <= !fb;
			fb_pulse <= fb;
		end
		@(posedge clk);
		{cmd_pulse, fb_pulse} <= 2'h0;
	endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the servo status block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// =====================================================================
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, sv, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] dn; // Drive state inputs, one bit each
	logic signed [15:0] motor_speed, analog_speed, speed_command;
	logic speed_select_bit0, speed_select_bit1, deviation_clear_in, cmd_pulse, cmd_dir, fb_pulse, fb_dir;
	wire logic [10:0] fo; // Function outputs in status bit order
	wire logic [5:0] do_pin;
	logic [10:0] e;
	logic [5:0] ep;
	int err_count, n_checks, seed, md, tt, dev, mp, ec, i;
	int rv[9] = '{0, 10, 3000, 100, 10, 100, 200, 300, 24'h075431}; // Register reset values
	sdio_status sdio_status_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_ok(dn[0]), .ctrl_alarm(dn[1]), .power_alarm(dn[2]), .other_alarm(dn[3]),
		.drive_energized(dn[4]), .servo_ok(dn[5]), .limit_fwd(dn[6]), .limit_rev(dn[7]),
		.emergency_stop(dn[8]), .comm_error(dn[9]), .under_voltage(dn[10]), .overload_level(dn[11]),
		.torque_limit_active(dn[12]), .brake_release(dn[13]), .motor_speed(motor_speed),
		.analog_speed(analog_speed), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .fb_pulse(fb_pulse),
		.fb_dir(fb_dir), .speed_select_bit0(speed_select_bit0), .speed_select_bit1(speed_select_bit1),
		.deviation_clear_in(deviation_clear_in), .speed_command(speed_command), .drive_ready_out(fo[0]),
		.energized_out(fo[1]), .zero_speed_out(fo[2]), .speed_reached_out(fo[3]),
		.position_reached_out(fo[4]), .torque_limiting_out(fo[5]), .fault_out(fo[6]),
		.brake_contact_out(fo[7]), .overload_out(fo[8]), .warning_out(fo[9]), .speed_match_out(fo[10]),
		.do_pin(do_pin), .irq(irq));
	sdio_host sdio_host_inst (.clk(clk), .speed_select_bit0(speed_select_bit0),
		.speed_select_bit1(speed_select_bit1), .deviation_clear_in(deviation_clear_in),
		.cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .fb_pulse(fb_pulse), .fb_dir(fb_dir));
	// =====================================================================
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic results();
		if (err_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] s);
		n_checks++;
		if (s !== x) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	// APB master; one idle edge after each transfer keeps drivers apart
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{psel, pwrite, paddr, pwdata, penable} <= {1'b1, w, a, d, 1'b0};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		sv = pslverr;
		{psel, penable} <= 2'h0;
		@(posedge clk);
	endtask
	function automatic int ab(input int v);
		return v < 0 ? -v : v;
	endfunction
	// Reference model of the status functions and the speed command
	task automatic settle();
		int s, c, k;
		repeat (3) @(posedge clk);
		s = motor_speed;
		c = {speed_select_bit1, speed_select_bit0};
		ec = c == 0 ? (md == 3 ? 0 : int'(analog_speed)) : 100 * c;
		e = {(md == 1 || md == 3) && ab(ec - s) < 10, |dn[10:6], dn[11], dn[13], |dn[3:1],
			dn[12] && md != 2 && md != 4, (md == 0 || md == 5 || md == 6) && ab(dev) < 100,
			ab(s) > tt, ab(s) < 10, dn[4] && dn[5], dn[0] && !dn[1] && !dn[2]};
		for (k = 0; k < 6; k++) begin
			c = (mp >> (4 * k)) & 15;
			ep[k] = (c >= 1 && c <= 11) ? e[c - 1] : 1'b0;
		end
		cmp("functions", e, fo);
		cmp("pins", ep, do_pin);
		cmp("speed command", 16'(ec), speed_command);
	endtask
	// =====================================================================
	// Watchdog: the whole sequence needs well under this many cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		results();
	end
	initial begin
		seed = 32'h0f2ca455;
		{psel, penable, pwrite, paddr, pwdata, dn, motor_speed, analog_speed} = '0;
		md = 0;
		dev = 0;
		tt = 3000;
		mp = 24'h075431;
		rstn = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		cmp("reset outputs", 0, {fo, do_pin, irq});
		for (i = 0; i < 9; i++) begin
			apb(1'b0, 8'(4 * i), 0);
			cmp("reset register", rv[i], rd);
		end
		apb(1'b0, 8'h34, 0);
		cmp("unmapped read", 0, rd);
		cmp("unmapped error", 1, sv);
		// Deviation window boundary, both signs, then clear
		sdio_host_inst.pulses(100, 1'b0, 1'b0);
		dev = 100;
		settle();
		sdio_host_inst.pulses(1, 1'b1, 1'b0);
		dev = 99;
		settle();
		sdio_host_inst.pulses(200, 1'b0, 1'b1);
		dev = -101;
		settle();
		sdio_host_inst.sel(2'h0, 1'b1);
		dev = 0;
		settle();
		sdio_host_inst.sel(2'h0, 1'b0);
		tt = 20;
		apb(1'b1, 8'h08, 20);
		// Every mode with a random pin map and random drive state
		for (md = 0; md < 8; md++) begin
			mp = $random(seed) & 24'hffffff;
			apb(1'b1, 8'h00, md);
			apb(1'b1, 8'h20, mp);
			repeat (25) begin
				dn <= 14'($random(seed));
				motor_speed <= 16'($random(seed) % 40);
				analog_speed <= 16'($random(seed) % 40);
				sdio_host_inst.sel(2'($random(seed)), 1'b0);
				settle();
				apb(1'b0, 8'h24, 0);
				cmp("status register", e, rd);
			end
		end
		md = 7;
		// Interrupt: raise while masked, unmask, then clear; a mask bit of one enables
		dn <= 14'h0;
		settle();
		apb(1'b1, 8'h2c, 32'h0);
		apb(1'b1, 8'h28, 32'h7ff);
		apb(1'b0, 8'h28, 0);
		cmp("irq status cleared", 0, rd);
		cmp("irq cleared", 0, irq);
		dn <= 14'h2;
		settle();
		apb(1'b0, 8'h28, 0);
		cmp("irq status", 32'h40, rd);
		cmp("irq masked", 0, irq);
		apb(1'b1, 8'h2c, 32'h7ff);
		cmp("irq raised", 1, irq);
		apb(1'b1, 8'h28, 32'h40);
		apb(1'b0, 8'h28, 0);
		cmp("irq status released", 0, rd);
		cmp("irq released", 0, irq);
		results();
	end
endmodule
`default_nettype wire
